/* File: inc/rstclk_pkg.sv */
package rstclk_pkg;
  // apb register map (byte offsets)
  localparam logic [7:0] OFF_CLKCTL  = 8'h00;
  localparam logic [7:0] OFF_TRAPCTL = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_VECTOR  = 8'h0c;
  // clock_mode_control_reg fields
  localparam int BIT_FASTEN = 7;
  localparam int BIT_SLOWEN = 6;
  localparam int BIT_CLKSEL = 5;
  // trap control fields
  localparam int BIT_TRAPRAM   = 0;
  localparam int BIT_TRAPRESET = 1;
  // reset values
  localparam logic [7:0] CLKCTL_RST  = 8'hc0;
  localparam logic [1:0] TRAPCTL_RST = 2'h2;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  // timing: pulse length in fast-clock periods, min external low time
  localparam int PULSE_PERIODS  = 24;
  localparam int EXTMIN_PERIODS = 12;
  localparam int SYNC_CYCLES    = 4;
  localparam logic [4:0] PULSE_CYCLES = 5'(PULSE_PERIODS);
  localparam logic [4:0] EXTMIN_CYCLES = 5'(EXTMIN_PERIODS);
  localparam logic [2:0] SYNC_CNT = 3'(SYNC_CYCLES);

  typedef enum {MODE_FAST1, MODE_FAST2, MODE_SLOW_SINGLE_CLOCK_MODE, MODE_SYNC} mode_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic wdtTimeout;
    logic fetchValid;
    logic fetchSfr;
    logic fetchRam;
  } reset_src_t;
endpackage : rstclk_pkg

/* File: rtl/pin_sync.sv */
module pin_sync (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;
  sync_t st;
  sync_t next_st;
  always_comb begin
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
  end
  // resets low: the power-up pulse holds the pin low, and a high
  // reset value would fake a release on the first edges
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.stage2;
endmodule : pin_sync

/* File: rtl/reset_and_clock_switch_control.sv */
// Behaviour
// [R1] fast oscillator enable bit set starts the fast oscillator
// [R2] clearing clock select moves main clock from slow to fast source
// [R3] software waits warm-up time before clearing clock select
// [R4] after select clears, run on slow clock until clocks synchronise; the code also leaves the slow clock when syncCnt runs out
// [R5] reset pin low ends slow mode; restart in fast single-clock mode
// [R6] four reset sources; trap, watchdog, clock fault share malfunction path
// [R7] malfunction request drives reset pin low for at most 24 periods
// [R8] malfunction logic not cleared at power-up; may pulse up to 24
// [R9] reset loads vector, clears irq master, enables and pending latches
// [R10] reset clears prescaler and divider, leaves watchdog enabled
// [R11] external low on reset pin lasts at least 12 fast periods
// [R12] pin high again releases reset; execution starts at the vector
// [R13] fetch from sfr, or ram when selected, raises address trap
// [R14] trap action reset or interrupt, and trapped area, are selectable
// [R15] after trap reset, vector read then target instruction fetched
// [R16] clock fault reset on illegal oscillator enable clears
// [R17] oscillator whose disable caused the clock fault keeps running
// [R18] clock select 1 picks slow clock, 0 picks fast clock
// [R19] clearing fast enable stops fast oscillator unless fault results
// [R20] internal reset held while reset pin is sensed low
// [R21] malfunction requests during an active pulse merge into it
module reset_and_clock_switch_control (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire rstclk_pkg::apb_req_t  apbReq,
  output rstclk_pkg::apb_rsp_t       apbRsp,
  input  wire logic                  resetPinIn,
  output logic                       resetPinOut,
  output logic                       resetPinOe,
  input  wire rstclk_pkg::reset_src_t srcIn,
  input  wire logic                  clocksAligned,
  output logic                       fastOscRun,
  output logic                       slowOscRun,
  output logic                       mainClkSlow,
  output logic                       coreReset,
  output logic [15:0]                pcLoad,
  output logic                       pcLoadStrobe,
  output logic                       irqStateClear,
  output logic                       prescalerClear,
  output logic                       watchdogEnable,
  output logic                       trapIrq
);
  typedef struct packed {
    logic [7:0]           clkCtl;
    logic [1:0]           trapCtl;
    rstclk_pkg::mode_t    mode;
    logic [4:0]           pulseCnt;
    logic                 pulseOn;
    logic [2:0]           syncCnt;
    logic                 inReset;
    logic                 vecLoad;
    logic [2:0]           lastCause;
    logic [31:0]          rdata;
    logic                 trapIrq;
  } state_t;

  state_t st;
  state_t next_st;
  logic   pinLevel;
  logic   apbWrite;
  logic   apbRead;
  logic   addrTrap;
  logic   clkFault;
  logic   malfReq;
  logic [7:0] wrCtl;

  // external pin is asynchronous: two flops before anything reads it
  pin_sync u_pin_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (resetPinIn),
    .dout    (pinLevel)
  );

  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign apbRead  = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  assign wrCtl    = apbReq.pwdata[7:0];

  always_comb begin
    addrTrap = srcIn.fetchValid && (srcIn.fetchSfr ||       // see [R13]
               (srcIn.fetchRam &&
                st.trapCtl[rstclk_pkg::BIT_TRAPRAM]));      // see [R14]
    clkFault = 1'b0;
    if (apbWrite && apbReq.paddr == rstclk_pkg::OFF_CLKCTL) begin
      // see [R16]
      clkFault =
        (!wrCtl[rstclk_pkg::BIT_FASTEN] && !wrCtl[rstclk_pkg::BIT_SLOWEN]) ||
        (!wrCtl[rstclk_pkg::BIT_FASTEN] &&
         !st.clkCtl[rstclk_pkg::BIT_CLKSEL]) ||
        (!wrCtl[rstclk_pkg::BIT_SLOWEN] &&
         st.clkCtl[rstclk_pkg::BIT_CLKSEL]);
    end
    malfReq = (addrTrap && st.trapCtl[rstclk_pkg::BIT_TRAPRESET]) ||
              srcIn.wdtTimeout || clkFault;                 // see [R6]
  end

  always_comb begin
    next_st = st;
    next_st.vecLoad = 1'b0;
    next_st.trapIrq = addrTrap && !st.trapCtl[rstclk_pkg::BIT_TRAPRESET];
    next_st.rdata = 32'h0;
    // malfunction pulse; requests during a pulse are merged  see [R21]
    if (st.pulseOn) begin
      if (st.pulseCnt == 5'h01) begin
        next_st.pulseOn = 1'b0;
      end
      next_st.pulseCnt = st.pulseCnt - 5'h01;
    end else if (malfReq) begin
      next_st.pulseOn  = 1'b1;                              // see [R7]
      next_st.pulseCnt = rstclk_pkg::PULSE_CYCLES;
      next_st.lastCause = {clkFault, srcIn.wdtTimeout, addrTrap};
    end
    // software writes, ignored while the core is held in reset or a malfunction pulse runs
    if (apbWrite && !st.inReset && !st.pulseOn) begin
      case (apbReq.paddr)
        rstclk_pkg::OFF_CLKCTL: begin
          next_st.clkCtl = wrCtl;                           // see [R1] [R19]
          if (clkFault) begin
            // the oscillator that was switched off keeps running  see [R17]
            next_st.clkCtl[rstclk_pkg::BIT_FASTEN] =
              st.clkCtl[rstclk_pkg::BIT_FASTEN];
            next_st.clkCtl[rstclk_pkg::BIT_SLOWEN] =
              st.clkCtl[rstclk_pkg::BIT_SLOWEN];
            next_st.clkCtl[rstclk_pkg::BIT_CLKSEL] =
              st.clkCtl[rstclk_pkg::BIT_CLKSEL];
          end else if (wrCtl[rstclk_pkg::BIT_CLKSEL]) begin
            next_st.mode = rstclk_pkg::MODE_SLOW_SINGLE_CLOCK_MODE;          // see [R18]
          end else if (st.mode == rstclk_pkg::MODE_SLOW_SINGLE_CLOCK_MODE) begin
            // relies on software having waited the warm-up  see [R3]
            next_st.mode    = rstclk_pkg::MODE_SYNC;        // see [R2]
            next_st.syncCnt = rstclk_pkg::SYNC_CNT;
          end
        end
        rstclk_pkg::OFF_TRAPCTL: begin
          next_st.trapCtl = apbReq.pwdata[1:0];             // see [R14]
        end
        default: begin
        end
      endcase
    end
    // bridge on the slow clock until both clocks line up or syncCnt runs out  see [R4]
    if (st.mode == rstclk_pkg::MODE_SYNC) begin
      if (clocksAligned || st.syncCnt == 3'h0) begin
        next_st.mode = rstclk_pkg::MODE_FAST2;
      end else begin
        next_st.syncCnt = st.syncCnt - 3'h1;
      end
    end
    if (apbRead) begin
      case (apbReq.paddr)
        rstclk_pkg::OFF_CLKCTL:  next_st.rdata = {24'h0, st.clkCtl};
        rstclk_pkg::OFF_TRAPCTL: next_st.rdata = {30'h0, st.trapCtl};
        rstclk_pkg::OFF_STATUS:
          next_st.rdata = {25'h0, st.lastCause, st.pulseOn,
                           st.mode == rstclk_pkg::MODE_SYNC,
                           st.clkCtl[rstclk_pkg::BIT_CLKSEL], st.inReset};
        rstclk_pkg::OFF_VECTOR:
          next_st.rdata = {16'h0, rstclk_pkg::RESET_VECTOR};
        default: next_st.rdata = 32'h0;
      endcase
    end
    // pin low (ours or external) holds the core in reset  see [R20] [R11]
    next_st.inReset = !pinLevel;
    if (!pinLevel) begin
      next_st.clkCtl  = rstclk_pkg::CLKCTL_RST;             // see [R5]
      next_st.trapCtl = rstclk_pkg::TRAPCTL_RST;
      next_st.mode    = rstclk_pkg::MODE_FAST1;
      next_st.trapIrq = 1'b0;
    end
    // release: fetch vector, then its target  see [R12] [R15]
    if (st.inReset && pinLevel) begin
      next_st.vecLoad = 1'b1;
    end
  end

  // malfunction pulse state is loaded at power-up on purpose:
  // a full 24-cycle pin pulse follows power-on  see [R8]
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st.clkCtl    <= rstclk_pkg::CLKCTL_RST;
      st.trapCtl   <= rstclk_pkg::TRAPCTL_RST;
      st.mode      <= rstclk_pkg::MODE_FAST1;
      st.pulseCnt  <= rstclk_pkg::PULSE_CYCLES;
      st.pulseOn   <= 1'b1;
      st.syncCnt   <= 3'h0;
      st.inReset   <= 1'b1;
      st.vecLoad   <= 1'b0;
      st.lastCause <= 3'h0;
      st.rdata     <= 32'h0;
      st.trapIrq   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = 1'b0;
  assign apbRsp.prdata  = st.rdata;
  // open drain: enable low while pulling the pin low  see [R7]
  assign resetPinOut    = 1'b0;
  assign resetPinOe     = !st.pulseOn;
  assign fastOscRun     = st.clkCtl[rstclk_pkg::BIT_FASTEN];
  assign slowOscRun     = st.clkCtl[rstclk_pkg::BIT_SLOWEN];
  // slow clock stays main during the sync bridge  see [R4]
  assign mainClkSlow    = st.mode == rstclk_pkg::MODE_SLOW_SINGLE_CLOCK_MODE ||
                          st.mode == rstclk_pkg::MODE_SYNC;
  assign coreReset      = st.inReset;
  assign pcLoad         = rstclk_pkg::RESET_VECTOR;         // see [R9]
  assign pcLoadStrobe   = st.vecLoad;
  assign irqStateClear  = st.inReset;                       // see [R9]
  assign prescalerClear = st.inReset;                       // see [R10]
  assign watchdogEnable = 1'b1;                             // see [R10]
  assign trapIrq        = st.trapIrq;

  sequence s_pulse_held;
    st.pulseOn [*8];
  endsequence
  sequence s_pulse_done;
    ##[0:16] !st.pulseOn;
  endsequence
  sequence s_bridge_slow;
    mainClkSlow;
  endsequence
  sequence s_bridge_left;
    ##[0:5] st.mode != rstclk_pkg::MODE_SYNC;
  endsequence

  a_pulse_length: assert property ( // see [R7]
    @(posedge sys_clk) disable iff (!rstn)
    $rose(st.pulseOn) |-> s_pulse_held ##1 s_pulse_done)
    else $error("malfunction pulse length wrong");
  a_pulse_merge: assert property ( // see [R21]
    @(posedge sys_clk) disable iff (!rstn)
    st.pulseOn && st.pulseCnt > 5'h01 |=> $stable(st.pulseOn))
    else $error("pulse restarted or cut");
  a_fault_detect: assert property ( // see [R16]
    @(posedge sys_clk) disable iff (!rstn)
    clkFault && !st.pulseOn |=> st.pulseOn)
    else $error("clock fault gave no reset");
  a_osc_kept: assert property ( // see [R17]
    @(posedge sys_clk) disable iff (!rstn)
    clkFault && pinLevel |=> $stable(fastOscRun) && $stable(slowOscRun))
    else $error("oscillator stopped on fault");
  a_pin_holds: assert property ( // see [R20]
    @(posedge sys_clk) disable iff (!rstn)
    !pinLevel |=> coreReset && prescalerClear)
    else $error("reset not held with pin low");
  a_release_vec: assert property ( // see [R12]
    @(posedge sys_clk) disable iff (!rstn)
    $fell(coreReset) |-> pcLoadStrobe && pcLoad == 16'hfffe)
    else $error("no vector load on release");
  a_reset_mode: assert property ( // see [R5]
    @(posedge sys_clk) disable iff (!rstn)
    $fell(coreReset) |-> !mainClkSlow)
    else $error("did not restart in fast mode");
  a_sync_bridge: assert property ( // see [R4]
    @(posedge sys_clk) disable iff (!rstn)
    st.mode == rstclk_pkg::MODE_SYNC |-> s_bridge_slow ##1 s_bridge_left)
    else $error("sync bridge wrong");
  a_trap_irq: assert property ( // see [R14]
    @(posedge sys_clk) disable iff (!rstn)
    addrTrap && !st.trapCtl[rstclk_pkg::BIT_TRAPRESET] && pinLevel
    |=> trapIrq)
    else $error("trap interrupt missing");
endmodule : reset_and_clock_switch_control

/* File: bench/reset_pin_model.sv */
module reset_pin_model #(
  parameter int LOW_CYCLES = 12
) (
  input  wire logic sys_clk,
  input  wire logic resetPinOe,
  input  wire logic extGo,
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  int holdCnt = 0;
  // pull-up: the pin reads high unless one side pulls it down
  assign pinLevel = !(resetPinOe === 1'b0 || holdCnt > 0);
  // an external pulse never runs shorter than the minimum low time
  always @(posedge sys_clk) begin
    if (extGo && holdCnt == 0) begin
      holdCnt <= LOW_CYCLES;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
endmodule : reset_pin_model

/* File: bench/reset_and_clock_switch_control_tb.sv */
module reset_and_clock_switch_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   sysClk, rstn, clocksAligned, extGo, pinLevel;
  rstclk_pkg::apb_req_t   req;
  rstclk_pkg::apb_rsp_t   rsp;
  rstclk_pkg::reset_src_t src;
  logic                   resetPinOut, resetPinOe, fastOscRun, slowOscRun;
  logic                   mainClkSlow, coreReset, pcLoadStrobe, trapIrq;
  logic                   irqStateClear, prescalerClear, watchdogEnable;
  logic [15:0]            pcLoad;
  logic [31:0]            rd;
  int                     n_mismatch = 0;
  int                     cmp_count = 0;

  reset_and_clock_switch_control i_dut (.sys_clk(sysClk), .rstn(rstn),
    .apbReq(req), .apbRsp(rsp), .resetPinIn(pinLevel),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .srcIn(src),
    .clocksAligned(clocksAligned), .fastOscRun(fastOscRun),
    .slowOscRun(slowOscRun), .mainClkSlow(mainClkSlow),
    .coreReset(coreReset), .pcLoad(pcLoad), .pcLoadStrobe(pcLoadStrobe),
    .irqStateClear(irqStateClear), .prescalerClear(prescalerClear),
    .watchdogEnable(watchdogEnable), .trapIrq(trapIrq));
  reset_pin_model i_pin (.sys_clk(sysClk), .resetPinOe(resetPinOe),
    .extGo(extGo), .pinLevel(pinLevel));

  initial begin
    sysClk = 1'b0;
    forever #4 sysClk = ~sysClk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int c);
    repeat (c) @(posedge sysClk);
    #1;
  endtask : idle

  // a slow slave only stretches the access phase; the bench timeout ends it
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge sysClk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sysClk);
    req.penable <= 1'b1;
    do @(posedge sysClk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    chk("slave error", 32'h0, 32'(rsp.pslverr));
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // exp of zero means any length from 1 to 24 cycles passes
  task automatic pulse(input int exp);
    int n;
    int w;
    n = 0;
    w = 0;
    // callers return on the launching edge: look once the pin has settled
    #1;
    while (pinLevel !== 1'b0 && w < 20) begin
      @(posedge sysClk) #1;
      w++;
    end
    while (pinLevel === 1'b0 && n < 100) begin
      @(posedge sysClk) #1;
      n++;
      if (n == 8) begin
        chk("reset outputs", 32'hf, 32'({coreReset,
          irqStateClear, prescalerClear, fastOscRun}));
        chk("pin drive", 32'(exp == rstclk_pkg::EXTMIN_PERIODS),
          32'({resetPinOut, resetPinOe}));
      end
    end
    if (exp == 0) chk("powerup pulse", 1, 32'(n > 0 && n <= 24));
    else chk("pulse length", exp, 32'(n));
    w = 0;
    while (coreReset !== 1'b0 && w < 20) begin
      @(posedge sysClk) #1;
      w++;
    end
    chk("vector strobe", 1, 32'(pcLoadStrobe));
    chk("vector", 32'hfffe, 32'(pcLoad));
    chk("watchdog on", 1, 32'(watchdogEnable));
  endtask : pulse

  task automatic trap(input logic [31:0] tc, input logic sfr, ram, rst, irq);
    logic seenIrq;
    seenIrq = 1'b0;
    apb(1'b1, rstclk_pkg::OFF_TRAPCTL, tc);
    @(posedge sysClk);
    src <= '{1'b0, 1'b1, sfr, ram};
    @(posedge sysClk);
    src <= '0;
    if (rst) pulse(24);
    else begin
      // the interrupt stands one cycle from this edge, so look at it first
      repeat (6) begin
        #1 seenIrq |= trapIrq;
        chk("no trap reset", 1, 32'(pinLevel));
        @(posedge sysClk);
      end
      chk("trap irq", 32'(irq), 32'(seenIrq));
    end
  endtask : trap

  task automatic reg_reset_values();
    apb(1'b0, rstclk_pkg::OFF_CLKCTL, 32'h0);
    chk("clock ctrl reset", 32'hc0, rd);
    apb(1'b0, rstclk_pkg::OFF_TRAPCTL, 32'h0);
    chk("trap ctrl reset", 32'h2, rd);
    apb(1'b0, rstclk_pkg::OFF_VECTOR, 32'h0);
    chk("vector reg", 32'hfffe, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : reg_reset_values

  task automatic clock_switch();
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'he0);
    idle(2);
    chk("to slow", 1, 32'(mainClkSlow));
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'h60);
    idle(2);
    chk("fast osc off", 32'h1, 32'({fastOscRun, slowOscRun}));
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'he0);
    idle(2);
    chk("fast osc on", 1, 32'(fastOscRun));
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'hc0);
    idle(2);
    chk("slow bridge", 1, 32'(mainClkSlow));
    // alignment must end the bridge before the fallback count runs out
    @(posedge sysClk) clocksAligned <= 1'b1;
    idle(1);
    chk("back to fast", 0, 32'(mainClkSlow));
    @(posedge sysClk) clocksAligned <= 1'b0;
  endtask : clock_switch

  // each illegal oscillator clear; the slow-selected one needs a setup
  task automatic clock_faults();
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'h40);
    #1 chk("osc 40", 32'h3, 32'({fastOscRun, slowOscRun}));
    pulse(24);
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'h00);
    #1 chk("osc 00", 32'h3, 32'({fastOscRun, slowOscRun}));
    pulse(24);
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'he0);
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'ha0);
    #1 chk("osc a0", 32'h3, 32'({fastOscRun, slowOscRun}));
    pulse(24);
    apb(1'b0, rstclk_pkg::OFF_CLKCTL, 32'h0);
    chk("clock ctrl after fault", 32'hc0, rd);
    apb(1'b0, rstclk_pkg::OFF_STATUS, 32'h0);
    chk("status clock fault", 32'h40, rd);
  endtask : clock_faults

  task automatic wdt_merge();
    fork
      pulse(24);
      begin
        @(posedge sysClk) src.wdtTimeout <= 1'b1;
        @(posedge sysClk) src.wdtTimeout <= 1'b0;
        repeat (8) @(posedge sysClk);
        src.wdtTimeout <= 1'b1;
        @(posedge sysClk) src.wdtTimeout <= 1'b0;
      end
    join
    apb(1'b0, rstclk_pkg::OFF_STATUS, 32'h0);
    chk("status watchdog", 32'h20, rd);
  endtask : wdt_merge

  task automatic ext_reset();
    apb(1'b1, rstclk_pkg::OFF_CLKCTL, 32'he0);
    idle(1);
    chk("slow before ext reset", 1, 32'(mainClkSlow));
    @(posedge sysClk) extGo <= 1'b1;
    @(posedge sysClk) extGo <= 1'b0;
    pulse(rstclk_pkg::EXTMIN_PERIODS);
    chk("fast after ext reset", 0, 32'(mainClkSlow));
    apb(1'b0, rstclk_pkg::OFF_TRAPCTL, 32'h0);
    chk("trap ctrl after ext reset", 32'h2, rd);
  endtask : ext_reset

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    #60000;
    n_mismatch++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    req = '0;
    src = '0;
    clocksAligned = 1'b0;
    extGo = 1'b0;
    repeat (16) @(posedge sysClk);
    rstn <= 1'b1;
    pulse(0);
    reg_reset_values();
    clock_switch();
    clock_faults();
    wdt_merge();
    trap(32'h2, 1'b1, 1'b0, 1'b1, 1'b0);
    trap(32'h3, 1'b0, 1'b1, 1'b1, 1'b0);
    trap(32'h2, 1'b0, 1'b1, 1'b0, 1'b0);
    trap(32'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    ext_reset();
    final_report();
  end
endmodule : reset_and_clock_switch_control_tb
